// >>> rtl/servo_io_pkg.sv
// package: constants, types and register map of the servo drive control i/o block
package servo_io_pkg;
  // ****************************************
  // register map (word index = byte address / 4 not used; plain port addresses)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DRIVE = 4'h1;
  localparam logic [3:0] ADDR_INPUTS = 4'h2;
  localparam logic [3:0] ADDR_SETPOINT = 4'h3;
  localparam logic [3:0] ADDR_QUAD_CNT = 4'h4;
  localparam logic [3:0] ADDR_PULSE_CNT = 4'h5;
  localparam logic [3:0] ADDR_PWM_HIGH = 4'h6;
  localparam logic [3:0] ADDR_PWM_PERIOD = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;

  // ctrl register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INIT_DONE_BIT = 2;
  localparam int CTRL_ENABLE_BIT = 3;
  localparam int CTRL_POSVEL_BIT = 4;

  // drive state register fields (firmware reported conditions)
  localparam int DRV_WARN_BIT = 0;
  localparam int DRV_FAULT_BIT = 1;
  localparam int DRV_BRAKE_BIT = 2;

  // interrupt status bits
  localparam int IRQ_CLEAR_BIT = 0;
  localparam int IRQ_HOME_BIT = 1;
  localparam int IRQ_POS_LIM_BIT = 2;
  localparam int IRQ_NEG_LIM_BIT = 3;
  localparam int IRQ_FAULT_BIT = 4;
  localparam int IRQ_W = 5;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int ADC_W = 12;
  localparam int CNT_W = 32;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int FAST_IN_MAX_MHZ = 4;
  // fewest clock cycles per half period of a fast input at its top rate
  localparam int FAST_HALF_CYC = CLK_MHZ / (2 * FAST_IN_MAX_MHZ);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_STEP_DIR = 2'b00,
    MODE_QUAD = 2'b01,
    MODE_PWM = 2'b10,
    MODE_ANALOG = 2'b11
  } setpoint_mode_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b10
  } drive_state_t;

  typedef struct packed {
    logic ready;
    logic track_warn;
    logic fault_stop;
    logic braking;
  } status_out_t;

  typedef struct packed {
    logic home;
    logic pos_feed;
    logic neg_feed;
    logic fault_clear;
  } gp_in_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// >>> rtl/in_sync.sv
// module: two flip-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/10ps
module in_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// >>> rtl/servo_drive_control_io.sv
// module: controller connector i/o logic of a servo drive
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// RULE_01: ready output high only after initialisation completes and commands are accepted.
// RULE_02: warning output high in position/velocity mode when tracking warning level reached.
// RULE_03: fault-stop output high whenever drive is stopped by a fault.
// RULE_04: braking output high while drive attempts to brake the motor.
// RULE_05: positive feed enable input gates motion in positive direction.
// RULE_06: negative feed enable input gates motion in negative direction.
// RULE_07: fault clear acts on rising edge only; steady level does nothing.
// RULE_08: if enabled when faults clear, motion resumes at once.
// RULE_09: first fast input is step, quadrature A or pwm by mode.
// RULE_10: second fast input is step direction or quadrature B by mode.
// RULE_11: fast inputs captured correctly up to 4 MHz toggle rate.
// RULE_12: fast input reads one when positive leg exceeds negative leg.
// RULE_13: analog input sampled at 12 bits, used as setpoint in analog mode.
// RULE_14: analog setpoint sign inverted while direction reversal input is high.
// RULE_15: status output conducts on logic one, blocks on logic zero.
// RULE_16: all digital and fast inputs synchronised before edge detection or decode.
// RULE_17: quadrature mode counts up or down by a/b phase order on each edge.
module servo_drive_control_io (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic fast_input_a_cmp_i,
  input wire logic fast_input_b_cmp_i,
  input wire servo_io_pkg::gp_in_t gp_in_i,
  input wire logic analog_dir_reverse_in_i,
  input wire logic [servo_io_pkg::ADC_W-1:0] analog_setpoint_in_i,
  input wire logic analog_valid_i,
  output servo_io_pkg::status_out_t status_out_o,
  output logic motion_enable_o,
  output logic pos_motion_ok_o,
  output logic neg_motion_ok_o,
  output logic fault_clear_pulse_o,
  output logic signed [servo_io_pkg::ADC_W:0] analog_setpoint_o,
  output logic irq_o
);
  import servo_io_pkg::*;

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [6:0] raw_in;
  logic [6:0] sync_in;
  logic fa;
  logic fb;
  logic dir_rev;
  gp_in_t gp;

  // comparator outputs already resolve + above - into one level
  assign raw_in = {fast_input_a_cmp_i, fast_input_b_cmp_i, analog_dir_reverse_in_i, gp_in_i}; // see RULE_12
  in_sync #(.W(7)) u_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  ); // see RULE_16
  assign fa = sync_in[6];
  assign fb = sync_in[5];
  assign dir_rev = sync_in[4];
  assign gp = gp_in_t'(sync_in[3:0]);

  // ****************************************
  // registers and previous values
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] drive_flags;
  logic [CNT_W-1:0] quad_cnt;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] pwm_high;
  logic [CNT_W-1:0] pwm_period;
  logic [CNT_W-1:0] pwm_run;
  logic [CNT_W-1:0] pwm_hcnt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic fa_q;
  logic fb_q;
  gp_in_t gp_q;
  drive_state_t state;
  drive_state_t next_state;

  setpoint_mode_t mode;
  logic init_done;
  logic enable;
  logic posvel;
  logic fault_req;

  assign mode = setpoint_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign init_done = ctrl[CTRL_INIT_DONE_BIT];
  assign enable = ctrl[CTRL_ENABLE_BIT];
  assign posvel = ctrl[CTRL_POSVEL_BIT];
  assign fault_req = drive_flags[DRV_FAULT_BIT];

  // ****************************************
  // edge detection on synchronised levels
  // ****************************************
  logic fa_rise;
  logic fa_fall;
  logic fa_edge;
  logic fb_edge;
  logic clear_rise;
  gp_in_t gp_change;

  // every edge seen: 12 cycles per half period at 4 MHz leaves margin
  assign fa_rise = fa & ~fa_q; // see RULE_11
  assign fa_fall = ~fa & fa_q;
  assign fa_edge = fa ^ fa_q;
  assign fb_edge = fb ^ fb_q;
  assign clear_rise = gp.fault_clear & ~gp_q.fault_clear; // see RULE_07
  assign gp_change = gp ^ gp_q;

  // ****************************************
  // quadrature and step decoding
  // ****************************************
  // direction from phase order: a leads b counts up
  function automatic logic quad_up(input logic a, input logic b, input logic a_ed);
    quad_up = a_ed ? (a != b) : (a == b);
  endfunction

  function automatic logic [CNT_W-1:0] step_cnt(input logic [CNT_W-1:0] c, input logic up);
    step_cnt = up ? c + 32'h0000_0001 : c - 32'h0000_0001;
  endfunction

  logic quad_step;
  logic quad_dir;
  logic step_pulse;
  logic step_dir;
  logic pos_ok;
  logic neg_ok;

  assign quad_step = (mode == MODE_QUAD) && (fa_edge ^ fb_edge); // see RULE_17
  assign quad_dir = quad_up(fa, fb, fa_edge); // see RULE_17
  assign step_pulse = (mode == MODE_STEP_DIR) && fa_rise; // see RULE_09
  assign step_dir = fb; // see RULE_10
  assign pos_ok = gp.pos_feed; // see RULE_05
  assign neg_ok = gp.neg_feed; // see RULE_06

  // ****************************************
  // drive state machine
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (fault_req) begin
          next_state = ST_FAULT;
        end else if (init_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_req) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // clear attempt succeeds only when no fault is still reported
        if (clear_rise && !fault_req) begin
          next_state = init_done ? ST_RUN : ST_INIT; // see RULE_07
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // setpoint counters and pwm measurement
  // ****************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fa_q <= 1'b0;
      fb_q <= 1'b0;
      gp_q <= gp_in_t'(4'h0);
    end else begin
      fa_q <= fa;
      fb_q <= fb;
      gp_q <= gp;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quad_cnt <= RESET_WORD;
      pulse_cnt <= RESET_WORD;
    end else begin
      if (quad_step) begin
        quad_cnt <= step_cnt(quad_cnt, quad_dir); // see RULE_17
      end
      if (step_pulse) begin
        pulse_cnt <= step_cnt(pulse_cnt, step_dir); // see RULE_09
      end
    end
  end

  // pwm: high time and period measured on channel a, in clocks
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_run <= RESET_WORD;
      pwm_hcnt <= RESET_WORD;
      pwm_high <= RESET_WORD;
      pwm_period <= RESET_WORD;
    end else if (mode == MODE_PWM) begin
      pwm_run <= fa_rise ? 32'h0000_0001 : pwm_run + 32'h0000_0001; // see RULE_09
      pwm_hcnt <= fa_rise ? 32'h0000_0001 : (fa ? pwm_hcnt + 32'h0000_0001 : pwm_hcnt);
      if (fa_rise) begin
        pwm_period <= pwm_run;
      end
      if (fa_fall) begin
        pwm_high <= pwm_hcnt;
      end
    end
  end

  // ****************************************
  // analog setpoint
  // ****************************************
  logic signed [ADC_W:0] adc_ext;
  assign adc_ext = {analog_setpoint_in_i[ADC_W-1], analog_setpoint_in_i}; // see RULE_13

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      analog_setpoint_o <= '0;
    end else if (analog_valid_i && mode == MODE_ANALOG) begin
      analog_setpoint_o <= dir_rev ? -adc_ext : adc_ext; // see RULE_14
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  status_out_t next_status;
  // logic one drives the isolated output transistor into conduction
  assign next_status.ready = (state == ST_RUN); // see RULE_01
  assign next_status.track_warn = posvel && drive_flags[DRV_WARN_BIT] && (mode != MODE_ANALOG || posvel); // see RULE_02
  assign next_status.fault_stop = (state == ST_FAULT); // see RULE_03
  assign next_status.braking = drive_flags[DRV_BRAKE_BIT]; // see RULE_04

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_out_o <= status_out_t'(4'h0);
      motion_enable_o <= 1'b0;
      pos_motion_ok_o <= 1'b0;
      neg_motion_ok_o <= 1'b0;
      fault_clear_pulse_o <= 1'b0;
    end else begin
      status_out_o <= next_status; // see RULE_15
      motion_enable_o <= enable && (next_state == ST_RUN); // see RULE_08
      pos_motion_ok_o <= pos_ok; // see RULE_05
      neg_motion_ok_o <= neg_ok; // see RULE_06
      fault_clear_pulse_o <= clear_rise; // see RULE_07
    end
  end

  // ****************************************
  // register port and interrupts
  // ****************************************
  logic [IRQ_W-1:0] irq_event;
  logic rd_status;
  logic [31:0] rd_mux;

  // order follows the package bits: fault entry, neg feed, pos feed, home, clear rise
  assign irq_event = {(next_state == ST_FAULT) && (state != ST_FAULT), gp_change.neg_feed, gp_change.pos_feed,
                      gp_change.home, clear_rise};
  assign rd_status = reg_rd_i && (reg_addr_i == ADDR_IRQ_STATUS);

  always_comb begin
    case (reg_addr_i)
      ADDR_CTRL: rd_mux = ctrl;
      ADDR_DRIVE: rd_mux = drive_flags;
      ADDR_INPUTS: rd_mux = {24'h00_0000, state, fa, fb, gp};
      ADDR_SETPOINT: rd_mux = {{(32-ADC_W-1){analog_setpoint_o[ADC_W]}}, analog_setpoint_o};
      ADDR_QUAD_CNT: rd_mux = quad_cnt;
      ADDR_PULSE_CNT: rd_mux = pulse_cnt;
      ADDR_PWM_HIGH: rd_mux = pwm_high;
      ADDR_PWM_PERIOD: rd_mux = pwm_period;
      ADDR_IRQ_STATUS: rd_mux = {27'h000_0000, irq_status};
      ADDR_IRQ_MASK: rd_mux = {27'h000_0000, irq_mask};
      default: rd_mux = RESET_WORD;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= RESET_WORD;
      drive_flags <= RESET_WORD;
      irq_mask <= '0;
      reg_rdata_o <= RESET_WORD;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
        ctrl <= {27'h000_0000, reg_wdata_i[4:0]};
      end
      if (reg_wr_i && reg_addr_i == ADDR_DRIVE) begin
        drive_flags <= {29'h0000_0000, reg_wdata_i[2:0]};
      end
      if (reg_wr_i && reg_addr_i == ADDR_IRQ_MASK) begin
        irq_mask <= reg_wdata_i[IRQ_W-1:0];
      end
      reg_rdata_o <= reg_rd_i ? rd_mux : RESET_WORD;
    end
  end

  // sticky status; a new event in the clearing read survives
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (rd_status ? '0 : irq_status) | irq_event;
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  a_ready_state: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    status_out_o.ready |-> $past(state) == ST_RUN) else $error("ready without run state"); // see RULE_01
  a_warn_mode: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    status_out_o.track_warn |-> $past(posvel) && $past(drive_flags[DRV_WARN_BIT])) else $error("bad warning"); // see RULE_02
  a_fault_stop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state == ST_FAULT) |=> status_out_o.fault_stop) else $error("fault stop not shown"); // see RULE_03
  a_brake_out: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    drive_flags[DRV_BRAKE_BIT] |=> status_out_o.braking) else $error("braking not shown"); // see RULE_04
  a_clear_edge: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state == ST_FAULT && gp.fault_clear && gp_q.fault_clear) |=> state == ST_FAULT)
    else $error("level cleared fault"); // see RULE_07
  a_resume_run: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state == ST_FAULT && clear_rise && !fault_req && enable && init_done) |=> motion_enable_o && state == ST_RUN)
    else $error("no resume after clear"); // see RULE_08
  a_quad_up: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (quad_step && quad_dir) |=> quad_cnt == $past(quad_cnt) + 32'h0000_0001) else $error("quad up miss"); // see RULE_17
  a_step_count: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (step_pulse && !fb) |=> pulse_cnt == $past(pulse_cnt) - 32'h0000_0001) else $error("step down miss"); // see RULE_10
  a_analog_inv: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (analog_valid_i && mode == MODE_ANALOG && dir_rev) |=> analog_setpoint_o == -$past(adc_ext))
    else $error("analog not inverted"); // see RULE_14
  a_feed_pos: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    pos_motion_ok_o == $past(gp.pos_feed)) else $error("pos feed mismatch"); // see RULE_05
  a_feed_neg: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    neg_motion_ok_o == $past(gp.neg_feed)) else $error("neg feed mismatch"); // see RULE_06

  c_fault_clear: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    state == ST_FAULT ##1 clear_rise ##1 state == ST_RUN);
  c_quad_count: cover property (@(posedge mclk_i) disable iff (!nrst_i) quad_step && !quad_dir);
  c_pwm_meas: cover property (@(posedge mclk_i) disable iff (!nrst_i) mode == MODE_PWM && fa_fall);
  c_irq_set: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(irq_o));
endmodule

// >>> testbench/motion_ctrl_model.sv
// partner model: motion controller and axis switches wired to the drive connector
`timescale 1ns/10ps
module motion_ctrl_model #(
  parameter int HALF = 12
) (
  input wire logic mclk_i,
  output logic fast_a_o,
  output logic fast_b_o,
  output servo_io_pkg::gp_in_t gp_o
);
  import servo_io_pkg::*;
  // comparator results and switch levels start low
  initial begin
    fast_a_o = 1'b0;
    fast_b_o = 1'b0;
    gp_o = '0;
  end
  // one half period at the fastest legal toggle rate
  task automatic half_wait();
    repeat (HALF) @(posedge mclk_i);
  endtask
  // both comparator results, held for a half period
  task automatic level(input logic a, input logic b);
    @(posedge mclk_i);
    fast_a_o <= a;
    fast_b_o <= b;
    half_wait();
  endtask
  // step pulses on a, direction level on b set up one half period ahead
  task automatic step(input logic dir, input int n);
    level(1'b0, dir);
    repeat (n) begin
      fast_a_o <= 1'b1;
      half_wait();
      fast_a_o <= 1'b0;
      half_wait();
    end
  endtask
  // full quadrature cycles, a leading for up and b leading for down
  task automatic quad(input logic up, input int n);
    @(posedge mclk_i);
    repeat (n) begin
      for (int i = 0; i < 4; i++) begin
        // leader then follower pattern 10, 11, 01, 00; a leads b when counting up
        if (up) begin
          {fast_a_o, fast_b_o} <= {i < 2, i == 1 || i == 2};
        end else begin
          {fast_b_o, fast_a_o} <= {i < 2, i == 1 || i == 2};
        end
        half_wait();
      end
    end
  endtask
  // switch levels as the limit and home switches present them
  task automatic set_gp(input gp_in_t v);
    @(posedge mclk_i);
    gp_o <= v;
  endtask
  // off-on-off pulse on the fault clear line
  task automatic clear_pulse();
    @(posedge mclk_i);
    gp_o.fault_clear <= 1'b1;
    half_wait();
    gp_o.fault_clear <= 1'b0;
  endtask
endmodule

// >>> testbench/servo_drive_control_io_tb.sv
// testbench: self-checking bench of the servo drive control i/o block
`timescale 1ns/10ps
module servo_drive_control_io_tb;
  import servo_io_pkg::*;
  // ********
  // signals and instances
  // ********
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic fast_a, fast_b, motion_en, pos_ok, neg_ok, clr_pulse, irq;
  logic dir_rev = 1'b0, an_valid = 1'b0;
  logic [11:0] an_smp = '0;
  gp_in_t gp;
  status_out_t status;
  logic signed [12:0] an_sp;
  logic [8:0] outs;
  logic [31:0] exp_q [$];
  int error_cnt = 0, tests_run = 0, cyc = 0, clr_cnt = 0;
  integer seed = 32'heca20ea7;
  assign outs = {status, motion_en, pos_ok, neg_ok, clr_pulse, irq};
  // 100 MHz clock
  always #5 mclk = ~mclk;
  servo_drive_control_io u_servo_drive_control_io (
    .mclk_i(mclk), .nrst_i(nrst), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .fast_input_a_cmp_i(fast_a), .fast_input_b_cmp_i(fast_b), .gp_in_i(gp),
    .analog_dir_reverse_in_i(dir_rev), .analog_setpoint_in_i(an_smp), .analog_valid_i(an_valid),
    .status_out_o(status), .motion_enable_o(motion_en), .pos_motion_ok_o(pos_ok),
    .neg_motion_ok_o(neg_ok), .fault_clear_pulse_o(clr_pulse), .analog_setpoint_o(an_sp), .irq_o(irq)
  );
  motion_ctrl_model #(.HALF(FAST_HALF_CYC)) u_motion_ctrl_model (
    .mclk_i(mclk), .fast_a_o(fast_a), .fast_b_o(fast_b), .gp_o(gp)
  );
  // ********
  // tasks
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // strobes stay up until the next access or idle lowers them
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    exp_q.push_back(e);
  endtask
  // lower strobes, wait n cycles and stop mid-cycle where outputs are settled
  task automatic idle(input int n);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic probe(input logic [8:0] e);
    check({23'h0, outs}, {23'h0, e});
  endtask
  // read data stand one cycle after the strobe; compare against the oldest note
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      check(reg_rdata, exp_q.pop_front());
    end
  end
  // pulse counter and hang guard
  always @(posedge mclk) begin
    cyc++;
    if (clr_pulse === 1'b1) begin
      clr_cnt++;
    end
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  // main sequence
  initial begin
    logic [31:0] v, s;
    logic signed [12:0] x;
    int n1, n2;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    idle(2);
    probe(9'h000);
    rd(ADDR_CTRL, RESET_WORD);
    rd(4'hf, 32'h0);
    rd(ADDR_INPUTS, 32'h0);
    for (int m = 0; m < 4; m++) begin
      v = ($random(seed) & 32'h10) | m;
      wr(ADDR_CTRL, v);
      wr(4'hc, $random(seed));
      rd(ADDR_CTRL, v);
    end
    idle(2);
    probe(9'h000);
    wr(ADDR_CTRL, 32'h1c);
    wr(ADDR_IRQ_MASK, 32'h04);
    idle(4);
    probe(9'h110);
    u_motion_ctrl_model.set_gp(4'b0100);
    idle(5);
    probe(9'h119);
    rd(ADDR_IRQ_STATUS, 32'h04);
    idle(2);
    probe(9'h118);
    rd(ADDR_IRQ_STATUS, 32'h0);
    idle(0);
    u_motion_ctrl_model.set_gp(4'b0110);
    idle(5);
    probe(9'h11c);
    rd(ADDR_IRQ_STATUS, 32'h08);
    rd(ADDR_INPUTS, 32'h46);
    wr(ADDR_DRIVE, 32'h5);
    idle(4);
    probe(9'h1bc);
    wr(ADDR_CTRL, 32'h0c);
    idle(4);
    probe(9'h13c);
    wr(ADDR_DRIVE, 32'h0);
    wr(ADDR_CTRL, 32'h1c);
    wr(ADDR_IRQ_MASK, 32'h10);
    wr(ADDR_DRIVE, 32'h2);
    idle(4);
    probe(9'h04d);
    u_motion_ctrl_model.set_gp(4'b0111);
    idle(4);
    wr(ADDR_DRIVE, 32'h0);
    idle(8);
    probe(9'h04d);
    rd(ADDR_IRQ_STATUS, 32'h11);
    idle(2);
    probe(9'h04c);
    u_motion_ctrl_model.set_gp(4'b0110);
    idle(4);
    u_motion_ctrl_model.clear_pulse();
    idle(2);
    probe(9'h11c);
    n1 = ($random(seed) & 7) + 1;
    n2 = ($random(seed) & 3) + 1;
    u_motion_ctrl_model.step(1'b1, n1);
    u_motion_ctrl_model.step(1'b0, n2);
    idle(4);
    rd(ADDR_PULSE_CNT, 32'(n1 - n2));
    wr(ADDR_CTRL, 32'h1d);
    idle(0);
    u_motion_ctrl_model.quad(1'b1, n1);
    u_motion_ctrl_model.quad(1'b0, n2);
    idle(4);
    rd(ADDR_QUAD_CNT, 32'(4 * (n1 - n2)));
    rd(ADDR_PULSE_CNT, 32'(n1 - n2));
    // pwm: two periods, each level held one half period plus the model's own edge
    wr(ADDR_CTRL, 32'h1e);
    idle(0);
    repeat (2) begin
      u_motion_ctrl_model.level(1'b1, 1'b0);
      u_motion_ctrl_model.level(1'b0, 1'b0);
    end
    rd(ADDR_PWM_HIGH, 32'(FAST_HALF_CYC + 1));
    rd(ADDR_PWM_PERIOD, 32'(2 * (FAST_HALF_CYC + 1)));
    wr(ADDR_CTRL, 32'h1f);
    idle(0);
    u_motion_ctrl_model.level(1'b1, 1'b0);
    rd(ADDR_INPUTS, 32'h66);
    idle(0);
    u_motion_ctrl_model.level(1'b0, 1'b1);
    rd(ADDR_INPUTS, 32'h56);
    // analog samples, the last one at the most negative code
    for (int i = 0; i < 3; i++) begin
      s = (i == 2) ? 32'h800 : $random(seed);
      idle(0);
      @(posedge mclk);
      dir_rev <= (i != 0);
      an_smp <= s[11:0];
      idle(4);
      @(posedge mclk);
      an_valid <= 1'b1;
      @(posedge mclk);
      an_valid <= 1'b0;
      x = {s[11], s[11:0]};
      if (i != 0) begin
        x = -x;
      end
      idle(2);
      check({19'h0, an_sp}, {19'h0, x});
      rd(ADDR_SETPOINT, 32'(x));
    end
    idle(2);
    check(32'(clr_cnt), 32'h0000_0002);
    conclude();
  end
endmodule
